//--- port_b_pkg.sv
package port_b_pkg;
  localparam int unsigned NUM_PINS = 6;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFF_BUZZER_CTRL = 8'h05;
  localparam logic [7:0] OFF_IR_CARRIER_CTRL = 8'h06;
  localparam logic [7:0] OFF_PORT_DATA = 8'h10;
  localparam logic [7:0] OFF_PORT_DIRECTION = 8'h11;
  localparam logic [7:0] OFF_PULL_HIGH = 8'h12;
  localparam logic [7:0] OFF_PULL_LOW = 8'h13;
  localparam logic [7:0] OFF_OPEN_DRAIN = 8'h14;
  localparam logic [7:0] OFF_LEVEL_CHANGE_MASK = 8'h15;
  localparam logic [7:0] OFF_IRQ_FLAG = 8'h16;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h17;
  localparam logic [7:0] OFF_POWER_CTRL = 8'h18;
  localparam logic [7:0] OFF_POWER_CTRL_ONE = 8'h19;
  localparam logic [7:0] OFF_READ_TYPE = 8'h1a;
  localparam logic [7:0] OFF_PIN_CONFIG = 8'h1b;

  // field positions
  localparam int unsigned BIT_BUZZER_EN = 7;
  localparam int unsigned BIT_IR_EN = 0;
  localparam int unsigned BIT_IR_57K = 1;
  localparam int unsigned BIT_IR_POL = 2;
  localparam int unsigned BIT_PORT_CHANGE = 1;
  localparam int unsigned BIT_EXT_IRQ_SEL = 6;
  localparam int unsigned BIT_GLOBAL_IRQ = 7;
  localparam int unsigned PULL_LOW_LSB = 4;
  localparam int unsigned CFG_EXT_RESET = 0;
  localparam int unsigned CFG_CLOCK_OUT = 1;
  localparam int unsigned CFG_PWM_PIN = 2;
  localparam int unsigned CFG_BUZZER_PIN = 3;

  // reset values
  localparam logic [7:0] RST_BUZZER_CTRL = 8'h0f;
  localparam logic [2:0] RST_IR_CTRL = 3'h0;
  localparam logic [5:0] RST_DIRECTION = 6'h3f;
  localparam logic [5:0] RST_ZERO6 = 6'h00;
  localparam logic [3:0] RST_ZERO4 = 4'h0;

  // ir carrier: divisions of the 4 MHz high-frequency oscillator tick
  localparam int unsigned HOSC_FREQ_KHZ = 4000;
  localparam logic [6:0] IR_DIV_57K = 7'h40;
  localparam logic [6:0] IR_DIV_38K = 7'h60;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_HALT,
    MODE_STANDBY,
    MODE_RESERVED
  } op_mode_t;
endpackage

//--- pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned WIDTH = 6
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cen_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else if (cen_i) begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

//--- port_b_pins_with_ir_buzzer.sv
`timescale 1ns/1ns
// Notes on behaviour
// [R1] buzzer codes 0-7 divide prescaler1 output by 2 up to 256
// [R2] code 8 gives timer1 output, codes 9-15 give timer1 count bits 1-7
// [R3] buzzer enable bit gates the buzzer waveform
// [R4] ir carrier enable switches carrier generation, resets to zero
// [R5] ir frequency bit picks 57 kHz when one, 38 kHz when zero
// [R6] polarity zero emits carrier on data one, polarity one on data zero
// [R7] carrier counts only 4 MHz oscillator ticks, dividing by 64 or 96
// [R8] enabled carrier is driven onto pin 1
// [R9] per-pin direction bits; one data register reads and writes pins
// [R10] each input pin has its own pull-high enable
// [R11] pins 0-3 pull-low enables sit in bits 7:4; pins 4-5 none
// [R12] per-pin open-drain select; pin 3 output is always open-drain
// [R13] change on a masked pin sets port change flag, flag register bit 1
// [R14] interrupt request when flag, its enable and global enable are set
// [R15] external interrupt select, power control bit 6, makes pin 0 an interrupt
// [R16] external interrupt wins; pin 0 change detection then disabled
// [R17] configured pin 3 low level requests chip reset
// [R18] configured pin 4 outputs instruction clock in normal or standby only
// [R19] pin 2 feeds timer0 and timer1 external clock per their selects
// [R20] pin 2 carries pwm1 when its enable and configuration allow
// [R21] pin 2 carries buzzer when its enable and configuration allow
// [R22] each pin read selects pad level or output latch
// [R23] change compares synchronised pin with previous sample
// [R24] port change flag stays set until software writes zero
module port_b_pins_with_ir_buzzer #(
  parameter int unsigned NUM_PINS = port_b_pkg::NUM_PINS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cen_i,
  input wire logic [port_b_pkg::ADDR_W-1:0] addr_i,
  input wire logic [port_b_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [port_b_pkg::DATA_W-1:0] rdata_o,
  input wire logic [5:0] pad_in_i,
  output logic [5:0] pad_out_o,
  output logic [5:0] pad_oe_o,
  output logic [5:0] pull_high_o,
  output logic [5:0] pull_low_o,
  input wire logic high_freq_osc_tick_i,
  input wire logic prescaler1_out_i,
  input wire logic timer1_out_i,
  input wire logic [7:0] timer1_count_i,
  input wire logic pwm1_i,
  input wire logic pwm_output_enable_i,
  input wire logic timer0_clock_select_i,
  input wire logic timer0_slow_clock_select_i,
  input wire logic timer1_clock_select_i,
  input wire port_b_pkg::op_mode_t op_mode_i,
  output logic timer0_ext_clock_o,
  output logic timer1_ext_clock_o,
  output logic ext_irq_o,
  output logic ext_reset_req_o,
  output logic irq_o
);
  import port_b_pkg::*;

  if (NUM_PINS != 6) begin : g_check
    $error("port_b_pins_with_ir_buzzer serves exactly six pins");
  end

  logic [7:0] buzzer_ctrl_q;
  logic [2:0] ir_ctrl_q;
  logic [5:0] data_q;
  logic [5:0] dir_q;
  logic [5:0] pull_high_q;
  logic [3:0] pull_low_q;
  logic [5:0] open_drain_q;
  logic [5:0] mask_q;
  logic port_change_flag_q;
  logic port_change_irq_enable_q;
  logic ext_irq_select_q;
  logic global_irq_enable_q;
  logic [5:0] read_type_q;
  logic [3:0] pin_cfg_q;
  logic [5:0] prev_q;
  logic [6:0] carrier_cnt_q;
  logic presc_prev_q;
  logic [7:0] bz_cnt_q;
  logic clk_obs_q;
  logic [5:0] pin_sync_w;

  pin_sync #(
    .WIDTH(6)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cen_i(cen_i),
    .async_i(pad_in_i),
    .sync_o(pin_sync_w)
  );

  // register decode
  wire wr_buzzer_w = wr_i && (addr_i == OFF_BUZZER_CTRL);
  wire wr_ir_w = wr_i && (addr_i == OFF_IR_CARRIER_CTRL);
  wire wr_data_w = wr_i && (addr_i == OFF_PORT_DATA);
  wire wr_dir_w = wr_i && (addr_i == OFF_PORT_DIRECTION);
  wire wr_ph_w = wr_i && (addr_i == OFF_PULL_HIGH);
  wire wr_pl_w = wr_i && (addr_i == OFF_PULL_LOW);
  wire wr_od_w = wr_i && (addr_i == OFF_OPEN_DRAIN);
  wire wr_mask_w = wr_i && (addr_i == OFF_LEVEL_CHANGE_MASK);
  wire wr_flag_w = wr_i && (addr_i == OFF_IRQ_FLAG);
  wire wr_ien_w = wr_i && (addr_i == OFF_IRQ_ENABLE);
  wire wr_pc_w = wr_i && (addr_i == OFF_POWER_CTRL);
  wire wr_pc1_w = wr_i && (addr_i == OFF_POWER_CTRL_ONE);
  wire wr_rt_w = wr_i && (addr_i == OFF_READ_TYPE);
  wire wr_cfg_w = wr_i && (addr_i == OFF_PIN_CONFIG);

  // direction bit one means input, matching the all-input reset state
  wire [5:0] is_out_w = ~dir_q; // R9
  wire [5:0] read_val_w = (read_type_q & data_q) | (~read_type_q & pin_sync_w); // R22

  logic [7:0] rd_mux_w;
  always_comb begin
    rd_mux_w = 8'h00;
    case (addr_i)
      OFF_PORT_DATA: rd_mux_w = {2'h0, read_val_w}; // R9
      OFF_PORT_DIRECTION: rd_mux_w = {2'h0, dir_q};
      OFF_PULL_HIGH: rd_mux_w = {2'h0, pull_high_q};
      OFF_PULL_LOW: rd_mux_w = {pull_low_q, 4'h0};
      OFF_OPEN_DRAIN: rd_mux_w = {2'h0, open_drain_q};
      OFF_LEVEL_CHANGE_MASK: rd_mux_w = {2'h0, mask_q};
      OFF_IRQ_FLAG: rd_mux_w = {6'h00, port_change_flag_q, 1'b0};
      OFF_IRQ_ENABLE: rd_mux_w = {6'h00, port_change_irq_enable_q, 1'b0};
      OFF_POWER_CTRL: rd_mux_w = {1'b0, ext_irq_select_q, 6'h00};
      OFF_POWER_CTRL_ONE: rd_mux_w = {global_irq_enable_q, 7'h00};
      OFF_READ_TYPE: rd_mux_w = {2'h0, read_type_q};
      OFF_PIN_CONFIG: rd_mux_w = {4'h0, pin_cfg_q};
      default: rd_mux_w = 8'h00;
    endcase
  end

  // level change; pin 0 is withheld while it serves the external interrupt
  wire [5:0] chg_mask_w = mask_q & {5'h1f, ~ext_irq_select_q}; // R16
  wire [5:0] change_w = (pin_sync_w ^ prev_q) & chg_mask_w; // R13 R23
  wire change_any_w = |change_w;
  // set wins over a software clear in the same cycle
  wire flag_clr_w = wr_flag_w && !wdata_i[BIT_PORT_CHANGE];
  wire flag_d = change_any_w || (port_change_flag_q && !flag_clr_w); // R24
  wire irq_d = port_change_flag_q && port_change_irq_enable_q && global_irq_enable_q; // R14

  // ir carrier
  wire ir_en_w = ir_ctrl_q[BIT_IR_EN];
  wire [6:0] ir_div_w = ir_ctrl_q[BIT_IR_57K] ? IR_DIV_57K : IR_DIV_38K; // R5 R7
  wire [6:0] ir_half_w = {1'b0, ir_div_w[6:1]};
  wire carrier_wave_w = ir_en_w && (carrier_cnt_q < ir_half_w);
  wire carrier_gate_w = ir_ctrl_q[BIT_IR_POL] ? !data_q[1] : data_q[1]; // R6
  wire ir_pin_w = carrier_wave_w && carrier_gate_w;
  logic [6:0] carrier_cnt_d;
  always_comb begin
    carrier_cnt_d = carrier_cnt_q;
    if (!ir_en_w) begin
      carrier_cnt_d = 7'h0; // R4
    end else if (carrier_cnt_q >= ir_div_w) begin
      // a switch to the shorter division must not leave the count stranded above it
      carrier_cnt_d = 7'h0; // R7
    end else if (high_freq_osc_tick_i) begin
      // counts oscillator ticks only, never the system clock
      carrier_cnt_d = (carrier_cnt_q >= ir_div_w - 7'h1) ? 7'h0 : carrier_cnt_q + 7'h1; // R7
    end
  end

  // buzzer; counter bit n toggles every 2^n prescaler edges, i.e. divides by 2^(n+1)
  wire presc_rise_w = prescaler1_out_i && !presc_prev_q;
  wire [3:0] bz_sel_w = buzzer_ctrl_q[3:0];
  logic bz_src_w;
  always_comb begin
    bz_src_w = 1'b0;
    if (!bz_sel_w[3]) begin
      bz_src_w = bz_cnt_q[bz_sel_w[2:0]]; // R1
    end else if (bz_sel_w[2:0] == 3'h0) begin
      bz_src_w = timer1_out_i; // R2
    end else begin
      bz_src_w = timer1_count_i[bz_sel_w[2:0]]; // R2
    end
  end
  wire bz_wave_w = buzzer_ctrl_q[BIT_BUZZER_EN] && bz_src_w; // R3

  // pin 2 function: pwm ahead of buzzer when both are allowed
  wire pwm_on_w = pwm_output_enable_i && pin_cfg_q[CFG_PWM_PIN]; // R20
  wire bz_on_w = buzzer_ctrl_q[BIT_BUZZER_EN] && pin_cfg_q[CFG_BUZZER_PIN]; // R21
  wire clk_obs_on_w = pin_cfg_q[CFG_CLOCK_OUT] &&
                      (op_mode_i == MODE_NORMAL || op_mode_i == MODE_STANDBY); // R18
  wire ext_rst_on_w = pin_cfg_q[CFG_EXT_RESET];

  logic [5:0] drv_val_w;
  logic [5:0] drv_en_w;
  always_comb begin
    drv_val_w = data_q;
    drv_en_w = is_out_w;
    if (ir_en_w) begin
      drv_val_w[1] = ir_pin_w; // R8
      drv_en_w[1] = 1'b1;
    end
    if (pwm_on_w) begin
      drv_val_w[2] = pwm1_i;
      drv_en_w[2] = 1'b1;
    end else if (bz_on_w) begin
      drv_val_w[2] = bz_wave_w;
      drv_en_w[2] = 1'b1;
    end
    if (ext_rst_on_w) begin
      drv_en_w[3] = 1'b0; // R17
    end
    if (clk_obs_on_w) begin
      drv_val_w[4] = clk_obs_q; // R18
      drv_en_w[4] = 1'b1;
    end
  end
  // open drain drives low only; pin 3 is open drain regardless of its bit
  wire [5:0] od_w = open_drain_q | 6'h08; // R12
  wire [5:0] oe_d = drv_en_w & (~od_w | ~drv_val_w); // R12
  wire [5:0] out_d = drv_val_w & ~od_w;
  wire [5:0] ph_d = pull_high_q & ~drv_en_w; // R10
  wire [5:0] pl_d = {2'h0, pull_low_q & ~drv_en_w[3:0]}; // R11

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buzzer_ctrl_q <= RST_BUZZER_CTRL;
      ir_ctrl_q <= RST_IR_CTRL;
      data_q <= RST_ZERO6;
      dir_q <= RST_DIRECTION;
      pull_high_q <= RST_ZERO6;
      pull_low_q <= RST_ZERO4;
      open_drain_q <= RST_ZERO6;
      mask_q <= RST_ZERO6;
      port_change_irq_enable_q <= 1'b0;
      ext_irq_select_q <= 1'b0;
      global_irq_enable_q <= 1'b0;
      read_type_q <= RST_ZERO6;
      pin_cfg_q <= RST_ZERO4;
    end else if (cen_i) begin
      if (wr_buzzer_w) buzzer_ctrl_q <= {wdata_i[BIT_BUZZER_EN], 3'h0, wdata_i[3:0]};
      if (wr_ir_w) ir_ctrl_q <= wdata_i[2:0]; // R4
      if (wr_data_w) data_q <= wdata_i[5:0]; // R9
      if (wr_dir_w) dir_q <= wdata_i[5:0]; // R9
      if (wr_ph_w) pull_high_q <= wdata_i[5:0];
      if (wr_pl_w) pull_low_q <= wdata_i[PULL_LOW_LSB +: 4]; // R11
      if (wr_od_w) open_drain_q <= wdata_i[5:0];
      if (wr_mask_w) mask_q <= wdata_i[5:0];
      if (wr_ien_w) port_change_irq_enable_q <= wdata_i[BIT_PORT_CHANGE];
      if (wr_pc_w) ext_irq_select_q <= wdata_i[BIT_EXT_IRQ_SEL]; // R15
      if (wr_pc1_w) global_irq_enable_q <= wdata_i[BIT_GLOBAL_IRQ];
      if (wr_rt_w) read_type_q <= wdata_i[5:0];
      if (wr_cfg_w) pin_cfg_q <= wdata_i[3:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_change_flag_q <= 1'b0;
      prev_q <= RST_ZERO6;
      carrier_cnt_q <= 7'h0;
      presc_prev_q <= 1'b0;
      bz_cnt_q <= 8'h00;
      clk_obs_q <= 1'b0;
    end else if (cen_i) begin
      port_change_flag_q <= flag_d; // R13
      prev_q <= pin_sync_w; // R23
      carrier_cnt_q <= carrier_cnt_d;
      presc_prev_q <= prescaler1_out_i;
      if (presc_rise_w) bz_cnt_q <= bz_cnt_q + 8'h01; // R1
      clk_obs_q <= !clk_obs_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
      pad_out_o <= RST_ZERO6;
      pad_oe_o <= RST_ZERO6;
      pull_high_o <= RST_ZERO6;
      pull_low_o <= RST_ZERO6;
      timer0_ext_clock_o <= 1'b0;
      timer1_ext_clock_o <= 1'b0;
      ext_irq_o <= 1'b0;
      ext_reset_req_o <= 1'b0;
      irq_o <= 1'b0;
    end else if (cen_i) begin
      rdata_o <= rd_i ? rd_mux_w : 8'h00;
      pad_out_o <= out_d;
      pad_oe_o <= oe_d;
      pull_high_o <= ph_d;
      pull_low_o <= pl_d;
      timer0_ext_clock_o <= timer0_clock_select_i && !timer0_slow_clock_select_i && pin_sync_w[2]; // R19
      timer1_ext_clock_o <= timer1_clock_select_i && pin_sync_w[2]; // R19
      ext_irq_o <= ext_irq_select_q && pin_sync_w[0]; // R15
      ext_reset_req_o <= ext_rst_on_w && !pin_sync_w[3]; // R17
      irq_o <= irq_d; // R14
    end
  end

  property p_change_sets_flag;
    @(posedge clk_i) disable iff (!rst_n_i) (cen_i && change_any_w) |=> port_change_flag_q;
  endproperty
  a_change_sets_flag: assert property (p_change_sets_flag) else $error("level change did not set flag"); // R13

  property p_flag_holds;
    @(posedge clk_i) disable iff (!rst_n_i)
      (port_change_flag_q && !(cen_i && flag_clr_w)) |=> port_change_flag_q;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag dropped without software clear"); // R24

  property p_irq_request;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cen_i && port_change_flag_q && port_change_irq_enable_q && global_irq_enable_q) |=> irq_o;
  endproperty
  a_irq_request: assert property (p_irq_request) else $error("interrupt request missing"); // R14

  property p_pin0_withheld;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cen_i && ext_irq_select_q && !port_change_flag_q && (((pin_sync_w ^ prev_q) & mask_q) == 6'h01))
      |=> !port_change_flag_q;
  endproperty
  a_pin0_withheld: assert property (p_pin0_withheld) else $error("pin 0 change seen under external interrupt"); // R16

  property p_pin3_open_drain;
    @(posedge clk_i) disable iff (!rst_n_i) pad_oe_o[3] |-> !pad_out_o[3];
  endproperty
  a_pin3_open_drain: assert property (p_pin3_open_drain) else $error("pin 3 driven high"); // R12

  property p_carrier_bound;
    @(posedge clk_i) disable iff (!rst_n_i) carrier_cnt_q < ir_div_w || $changed(ir_ctrl_q) || !$past(cen_i);
  endproperty
  a_carrier_bound: assert property (p_carrier_bound) else $error("carrier counter beyond division"); // R7

  property p_carrier_off;
    @(posedge clk_i) disable iff (!rst_n_i) (cen_i && !ir_en_w) |=> (carrier_cnt_q == 7'h0);
  endproperty
  a_carrier_off: assert property (p_carrier_off) else $error("carrier counting while disabled"); // R4

  property p_buzzer_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cen_i && !buzzer_ctrl_q[BIT_BUZZER_EN] && !pwm_on_w && !is_out_w[2]) |=> !pad_oe_o[2];
  endproperty
  a_buzzer_gate: assert property (p_buzzer_gate) else $error("buzzer wave while disabled"); // R3

  property p_ext_reset;
    @(posedge clk_i) disable iff (!rst_n_i) (cen_i && ext_rst_on_w && !pin_sync_w[3]) |=> ext_reset_req_o;
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("external reset request missing"); // R17

  property p_read_window;
    @(posedge clk_i) disable iff (!rst_n_i) (cen_i && !rd_i) |=> (rdata_o == 8'h00);
  endproperty
  a_read_window: assert property (p_read_window) else $error("read data outside its cycle"); // R9
endmodule

//--- pins_model.sv
`timescale 1ns/1ns
module pins_model (
  input wire logic clk_i,
  input wire logic [5:0] pad_out_i,
  input wire logic [5:0] pad_oe_i,
  input wire logic [5:0] pull_high_i,
  input wire logic [5:0] pull_low_i,
  input wire logic [5:0] sw_en_i,
  input wire logic [5:0] sw_val_i,
  output logic [5:0] pad_o
);
  logic [5:0] last_q = 6'h00;
  // a pin nobody holds flips every cycle, so a stale level never reads as valid
  always @(posedge clk_i) begin
    last_q <= pad_o;
  end
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pad_o[i] = pad_oe_i[i] ? pad_out_i[i] : sw_en_i[i] ? sw_val_i[i] :
                 pull_high_i[i] ? 1'b1 : pull_low_i[i] ? 1'b0 : ~last_q[i];
    end
  end
endmodule

//--- port_b_pins_with_ir_buzzer_bench.sv
`timescale 1ns/1ns
module port_b_pins_with_ir_buzzer_bench;
  import port_b_pkg::*;
  logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, tick = 0, tick_en = 0, prev1 = 0, cen = 1;
  logic pre = 0, t1_out = 0, pwm = 0, pwm_en = 0, timer0_clock_select = 0, t0slow = 0, timer1_clock_select = 0;
  logic t0ck, t1ck, eirq, erst, irq, a, b;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, t1_cnt = 8'h00, rd;
  logic [7:0] period = 8'h00, tcnt = 8'h00, rises = 8'h00, n0;
  logic [5:0] pad_in, pad_out_o, pad_oe_o, ph, pl, sw_en = 6'h00, sw_val = 6'h00;
  logic [2:0] tdiv = 3'h0;
  op_mode_t mode = MODE_NORMAL;
  int errors = 0, cmp_count = 0, cycles = 0, i, tg;

  always #20 clk_i = ~clk_i;

  port_b_pins_with_ir_buzzer u_dut (.clk_i, .rst_n_i, .cen_i(cen), .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .pad_in_i(pad_in), .pad_out_o, .pad_oe_o, .pull_high_o(ph), .pull_low_o(pl),
    .high_freq_osc_tick_i(tick), .prescaler1_out_i(pre), .timer1_out_i(t1_out), .timer1_count_i(t1_cnt),
    .pwm1_i(pwm), .pwm_output_enable_i(pwm_en), .timer0_clock_select_i(timer0_clock_select),
    .timer0_slow_clock_select_i(t0slow), .timer1_clock_select_i(timer1_clock_select), .op_mode_i(mode),
    .timer0_ext_clock_o(t0ck), .timer1_ext_clock_o(t1ck), .ext_irq_o(eirq), .ext_reset_req_o(erst),
    .irq_o(irq));

  pins_model u_pins (.clk_i, .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .pull_high_i(ph),
    .pull_low_i(pl), .sw_en_i(sw_en), .sw_val_i(sw_val), .pad_o(pad_in));

  // oscillator tick roughly every 6 clocks; carrier periods are counted in ticks
  always @(posedge clk_i) begin
    tdiv <= (tdiv == 3'd5) ? 3'd0 : tdiv + 3'd1;
    tick <= tick_en && tdiv == 3'd5;
    prev1 <= pad_out_o[1];
    cycles <= cycles + 1;
    if (pad_out_o[1] === 1'b1 && prev1 === 1'b0) begin
      period <= tcnt;
      tcnt <= 8'h00;
      rises <= rises + 8'h01;
    end else if (tick) begin
      tcnt <= tcnt + 8'h01;
    end
    if (cycles == 30000) begin
      errors++;
      $display("[FAIL] timeout expected end seen hang");
      results();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= ad;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rc(input string what, input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= ad;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rd = rdata_o;
    chk(what, exp, rd);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rc("direction", OFF_PORT_DIRECTION, 8'h3f);
    rc("buzzer_wo", OFF_BUZZER_CTRL, 8'h00);
    rc("unmapped", 8'h40, 8'h00);
    chk("oe_reset", 8'h00, 8'(pad_oe_o));
    cen <= 1'b0;
    wr(OFF_PORT_DIRECTION, 8'h00);
    cen <= 1'b1;
    rc("cen_frozen", OFF_PORT_DIRECTION, 8'h3f);
    $display("test reset done");
    wr(OFF_PORT_DIRECTION, 8'h00);
    wr(OFF_PORT_DATA, 8'h2a);
    settle(3);
    chk("pad_out", 8'h22, 8'(pad_out_o));
    chk("pad_oe", 8'h37, 8'(pad_oe_o));
    wr(OFF_OPEN_DRAIN, 8'h01);
    wr(OFF_PORT_DATA, 8'h3f);
    settle(3);
    chk("od_out", 8'h36, 8'(pad_out_o));
    chk("od_oe", 8'h36, 8'(pad_oe_o));
    sw_en <= 6'h09;
    sw_val <= 6'h08;
    wr(OFF_READ_TYPE, 8'h01);
    rc("read_latch", OFF_PORT_DATA, 8'h3f);
    wr(OFF_READ_TYPE, 8'h00);
    settle(3);
    rc("read_pad", OFF_PORT_DATA, 8'h3e);
    $display("test outputs done");
    wr(OFF_PORT_DIRECTION, 8'h3f);
    sw_en <= 6'h00;
    wr(OFF_PULL_HIGH, 8'h15);
    settle(3);
    chk("pull_high", 8'h15, 8'(ph));
    wr(OFF_PULL_HIGH, 8'h00);
    wr(OFF_PULL_LOW, 8'hff);
    settle(3);
    chk("pull_low", 8'h0f, 8'(pl));
    wr(OFF_PULL_LOW, 8'h00);
    wr(OFF_PULL_HIGH, 8'h3f);
    $display("test pulls done");
    wr(OFF_LEVEL_CHANGE_MASK, 8'h04);
    wr(OFF_IRQ_ENABLE, 8'h02);
    wr(OFF_POWER_CTRL_ONE, 8'h80);
    wr(OFF_IRQ_FLAG, 8'h00);
    settle(4);
    chk("irq_idle", 8'h00, 8'(irq));
    sw_en <= 6'h04;
    settle(6);
    chk("irq_set", 8'h01, 8'(irq));
    settle(20);
    rc("flag_held", OFF_IRQ_FLAG, 8'h02);
    wr(OFF_IRQ_FLAG, 8'h00);
    settle(3);
    chk("irq_clear", 8'h00, 8'(irq));
    sw_en <= 6'h24;
    settle(6);
    rc("unmasked", OFF_IRQ_FLAG, 8'h00);
    wr(OFF_POWER_CTRL_ONE, 8'h00);
    sw_val <= 6'h04;
    settle(6);
    chk("irq_global", 8'h00, 8'(irq));
    rc("flag_masked", OFF_IRQ_FLAG, 8'h02);
    $display("test level change done");
    wr(OFF_IRQ_FLAG, 8'h00);
    wr(OFF_LEVEL_CHANGE_MASK, 8'h01);
    wr(OFF_POWER_CTRL, 8'h40);
    sw_en <= 6'h01;
    sw_val <= 6'h00;
    settle(6);
    chk("ext_irq_lo", 8'h00, 8'(eirq));
    rc("pin0_blocked", OFF_IRQ_FLAG, 8'h00);
    sw_val <= 6'h01;
    settle(6);
    chk("ext_irq_hi", 8'h01, 8'(eirq));
    sw_en <= 6'h08;
    sw_val <= 6'h00;
    wr(OFF_PIN_CONFIG, 8'h01);
    settle(4);
    chk("ext_rst_lo", 8'h01, 8'(erst));
    sw_val <= 6'h08;
    settle(4);
    chk("ext_rst_hi", 8'h00, 8'(erst));
    $display("test pin functions done");
    wr(OFF_PIN_CONFIG, 8'h02);
    for (i = 0; i < 4; i++) begin
      mode <= op_mode_t'(i);
      settle(3);
      a = pad_out_o[4];
      settle(1);
      chk("clk_out", 8'(i == 0 || i == 2), 8'(a ^ pad_out_o[4]));
    end
    mode <= MODE_NORMAL;
    wr(OFF_PIN_CONFIG, 8'h00);
    timer0_clock_select <= 1'b1;
    timer1_clock_select <= 1'b1;
    sw_en <= 6'h04;
    sw_val <= 6'h04;
    settle(5);
    chk("ext_clk_hi", 8'h03, {6'h00, t0ck, t1ck});
    sw_val <= 6'h00;
    settle(5);
    chk("ext_clk_lo", 8'h00, {6'h00, t0ck, t1ck});
    sw_val <= 6'h04;
    t0slow <= 1'b1;
    timer1_clock_select <= 1'b0;
    settle(5);
    chk("ext_clk_off", 8'h00, {6'h00, t0ck, t1ck});
    sw_en <= 6'h00;
    $display("test clocks done");
    wr(OFF_PIN_CONFIG, 8'h0c);
    pwm_en <= 1'b1;
    pwm <= 1'b1;
    settle(3);
    chk("pwm_hi", 8'h03, {6'h00, pad_oe_o[2], pad_out_o[2]});
    pwm <= 1'b0;
    settle(3);
    chk("pwm_lo", 8'h02, {6'h00, pad_oe_o[2], pad_out_o[2]});
    pwm_en <= 1'b0;
    wr(OFF_BUZZER_CTRL, 8'h88);
    t1_out <= 1'b1;
    settle(3);
    chk("bz_t1", 8'h03, {6'h00, pad_oe_o[2], pad_out_o[2]});
    for (i = 1; i < 8; i++) begin
      wr(OFF_BUZZER_CTRL, 8'h88 + 8'(i));
      t1_cnt <= 8'h01 << i;
      settle(3);
      chk("bz_bit_hi", 8'h01, 8'(pad_out_o[2]));
      t1_cnt <= ~(8'h01 << i);
      settle(3);
      chk("bz_bit_lo", 8'h00, 8'(pad_out_o[2]));
    end
    for (i = 0; i < 8; i++) begin
      wr(OFF_BUZZER_CTRL, 8'h80 + 8'(i));
      settle(3);
      tg = 0;
      a = pad_out_o[2];
      repeat (2 << i) begin
        pre <= 1'b1;
        settle(1);
        pre <= 1'b0;
        settle(2);
        b = pad_out_o[2];
        if (b !== a) tg++;
        a = b;
      end
      chk("bz_div", 8'h02, 8'(tg));
    end
    wr(OFF_BUZZER_CTRL, 8'h08);
    settle(3);
    chk("bz_off", 8'h00, 8'(pad_oe_o[2]));
    $display("test buzzer done");
    wr(OFF_PIN_CONFIG, 8'h00);
    wr(OFF_PORT_DIRECTION, 8'h3d);
    wr(OFF_PORT_DATA, 8'h02);
    tick_en <= 1'b1;
    settle(3);
    chk("ir_reset", 8'h01, 8'(pad_out_o[1]));
    wr(OFF_IR_CARRIER_CTRL, 8'h03);
    settle(1200);
    chk("ir_57k", 8'd64, period);
    wr(OFF_IR_CARRIER_CTRL, 8'h01);
    settle(1800);
    chk("ir_38k", 8'd96, period);
    wr(OFF_IR_CARRIER_CTRL, 8'h05);
    settle(20);
    n0 = rises;
    settle(700);
    chk("ir_pol_quiet", 8'h00, rises - n0);
    wr(OFF_PORT_DATA, 8'h00);
    settle(1800);
    chk("ir_pol_low", 8'd96, period);
    tick_en <= 1'b0;
    settle(20);
    n0 = rises;
    settle(700);
    chk("ir_no_osc", 8'h00, rises - n0);
    wr(OFF_IR_CARRIER_CTRL, 8'h00);
    settle(3);
    chk("ir_off", 8'h00, 8'(pad_out_o[1]));
    $display("test ir done");
    results();
  end
endmodule
